// File: core/slkd_top.sv
// Combined lock detector for main, auxiliary and offset loops
module slkd_top
    import slkd_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Loop enables from the control logic (same clock)
    input  wire logic main_loop_enable_in,
    input  wire logic aux_loop_enable_in,
    input  wire logic offset_synth_enable_in,
    // Asynchronous inputs from the synthesizer
    input  wire logic reference_input_in,
    input  wire logic main_ref_pulse_in,
    input  wire logic main_div_pulse_in,
    input  wire logic aux_ref_pulse_in,
    input  wire logic aux_div_pulse_in,
    input  wire logic offset_pd_lock_in,
    // Lock indications
    output logic      main_lock_out,
    output logic      aux_lock_out,
    output logic      lock_out
);

    logic [SYN_W-1:0] sync1_q;
    logic [SYN_W-1:0] sync2_q;
    logic [SYN_W-1:0] prev_q;
    logic [SYN_W-1:0] raw;
    logic             offset_lock_eff;
    logic             lock_q;
    logic             main_lock_q;
    logic             aux_lock_q;

    slkd_loop_if main_if ();
    slkd_loop_if aux_if ();

    // Divider pulses act on their falling edge, as the detector does
    function automatic logic fall_edge(input logic prev, input logic cur);
        fall_edge = prev && !cur;
    endfunction : fall_edge

    function automatic logic rise_edge(input logic prev, input logic cur);
        rise_edge = !prev && cur;
    endfunction : rise_edge

    assign raw[SYN_REF_POS]      = reference_input_in;
    assign raw[SYN_MAIN_R_POS]   = main_ref_pulse_in;
    assign raw[SYN_MAIN_V_POS]   = main_div_pulse_in;
    assign raw[SYN_AUX_R_POS]    = aux_ref_pulse_in;
    assign raw[SYN_AUX_V_POS]    = aux_div_pulse_in;
    assign raw[SYN_OFS_LOCK_POS] = offset_pd_lock_in;

    // Two-stage synchroniser; only stage two feeds any logic.
    // Pulses must stay at least two clocks in each level to be seen.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= {SYN_W{SYNC_RST_VAL}};
            sync2_q <= {SYN_W{SYNC_RST_VAL}};
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // Delayed copy of stage two for edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= {SYN_W{SYNC_RST_VAL}};
        end else begin
            prev_q <= sync2_q;
        end
    end

    // Main loop window
    assign main_if.enable    = main_loop_enable_in;
    assign main_if.ref_tick  = rise_edge(prev_q[SYN_REF_POS],
                                         sync2_q[SYN_REF_POS]);
    assign main_if.ref_pulse = fall_edge(prev_q[SYN_MAIN_R_POS],
                                         sync2_q[SYN_MAIN_R_POS]);
    assign main_if.div_pulse = fall_edge(prev_q[SYN_MAIN_V_POS],
                                         sync2_q[SYN_MAIN_V_POS]);

    // Auxiliary loop window
    assign aux_if.enable     = aux_loop_enable_in;
    assign aux_if.ref_tick   = main_if.ref_tick;
    assign aux_if.ref_pulse  = fall_edge(prev_q[SYN_AUX_R_POS],
                                         sync2_q[SYN_AUX_R_POS]);
    assign aux_if.div_pulse  = fall_edge(prev_q[SYN_AUX_V_POS],
                                         sync2_q[SYN_AUX_V_POS]);

    slkd_phase_win #(
        .CNT_W (EDGE_CNT_W)
    ) u_main_win (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .lp       (main_if.win)
    );

    slkd_phase_win #(
        .CNT_W (EDGE_CNT_W)
    ) u_aux_win (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .lp       (aux_if.win)
    );

    // Standby forces the offset loop to read as locked
    assign offset_lock_eff = !offset_synth_enable_in ||
                             sync2_q[SYN_OFS_LOCK_POS];

    // Combined lock, registered so the controller sees no glitches
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_q <= LOCK_RST_VAL;
        end else begin
            lock_q <= main_if.locked && aux_if.locked &&
                      offset_lock_eff;
        end
    end

    // Per-loop indications, aligned with the combined output
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            main_lock_q <= LOCK_RST_VAL;
            aux_lock_q  <= LOCK_RST_VAL;
        end else begin
            main_lock_q <= main_if.locked;
            aux_lock_q  <= aux_if.locked;
        end
    end

    assign lock_out      = lock_q;
    assign main_lock_out = main_lock_q;
    assign aux_lock_out  = aux_lock_q;

endmodule : slkd_top

// File: core/slkd_pkg.sv
// Constants and types shared by the synthesizer lock detector
// Notes on behaviour
// - Lock output is AND of three lock indications
// - Offset standby forces offset lock indication true
// - Loop locked when phase error under one reference cycle
// - Disabled main or aux loop counts as locked
// - Loop enable high turns on its comparison stage
package slkd_pkg;

    // Tolerated phase error, in reference input cycles
    localparam int unsigned LOCK_TOL_REF_CYC = 1;
    // Reference edges inside one comparison that prove the error too big
    localparam int unsigned LOCK_FAIL_EDGES  = LOCK_TOL_REF_CYC + 1;
    // Width of the per-loop reference edge counter
    localparam int unsigned EDGE_CNT_W       = 2;

    // Reset values
    localparam logic LOCK_RST_VAL = 1'b0;
    localparam logic SYNC_RST_VAL = 1'b0;

    // Bit positions inside the synchroniser vector
    localparam int unsigned SYN_REF_POS      = 0;
    localparam int unsigned SYN_MAIN_R_POS   = 1;
    localparam int unsigned SYN_MAIN_V_POS   = 2;
    localparam int unsigned SYN_AUX_R_POS    = 3;
    localparam int unsigned SYN_AUX_V_POS    = 4;
    localparam int unsigned SYN_OFS_LOCK_POS = 5;
    localparam int unsigned SYN_W            = 6;

    // Comparison window states, Gray along idle-wait-idle
    typedef enum logic [1:0] {
        SLKD_IDLE     = 2'b00,
        SLKD_REF_LEAD = 2'b01,
        SLKD_DIV_LEAD = 2'b10
    } slkd_win_state_t;

endpackage : slkd_pkg

// File: core/slkd_loop_if.sv
// Signals between the lock detector top and one loop's phase window
interface slkd_loop_if;
    logic enable;    // Loop enable from control logic
    logic ref_tick;  // One-cycle pulse per reference input cycle
    logic ref_pulse; // One-cycle pulse: reference divider output
    logic div_pulse; // One-cycle pulse: loop divider output
    logic locked;    // Lock indication of this loop

    modport win (
        input  enable,
        input  ref_tick,
        input  ref_pulse,
        input  div_pulse,
        output locked
    );

    modport top (
        output enable,
        output ref_tick,
        output ref_pulse,
        output div_pulse,
        input  locked
    );
endinterface : slkd_loop_if

// File: core/slkd_phase_win.sv
// Phase window checker for one integer-N loop
module slkd_phase_win
    import slkd_pkg::*;
#(
    parameter int unsigned CNT_W = EDGE_CNT_W
) (
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    // Loop signals
    slkd_loop_if.win   lp
);

    // Refuse a counter that cannot reach the fail count at elaboration
    if (CNT_W < 1 || (2 ** CNT_W) <= LOCK_FAIL_EDGES) begin : g_cnt_w_bad
        $error("slkd_phase_win: CNT_W too small for the lock window");
    end

    localparam logic [CNT_W-1:0] FAIL_CNT = CNT_W'(LOCK_FAIL_EDGES);
    localparam logic [CNT_W-1:0] ZERO_CNT = '0;

    slkd_win_state_t  state_q;
    slkd_win_state_t  state_d;
    logic [CNT_W-1:0] cnt_q;
    logic             locked_q;
    logic             lag_seen;
    logic             both_now;

    // The second pulse closes the comparison
    assign both_now = lp.ref_pulse && lp.div_pulse;
    assign lag_seen = (state_q == SLKD_REF_LEAD && lp.div_pulse) ||
                      (state_q == SLKD_DIV_LEAD && lp.ref_pulse);

    // Window sequencing; a disabled loop just parks in idle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SLKD_IDLE: begin
                if (both_now) begin
                    state_d = SLKD_IDLE;
                end else if (lp.ref_pulse) begin
                    state_d = SLKD_REF_LEAD;
                end else if (lp.div_pulse) begin
                    state_d = SLKD_DIV_LEAD;
                end
            end
            SLKD_REF_LEAD,
            SLKD_DIV_LEAD: begin
                if (lag_seen) begin
                    state_d = SLKD_IDLE;
                end
            end
            default: begin
                state_d = SLKD_IDLE; // Two-bit code 11 is illegal
            end
        endcase
        if (!lp.enable) begin
            state_d = SLKD_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= SLKD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Count reference cycles while the lagging pulse is awaited
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= ZERO_CNT;
        end else if (state_q == SLKD_IDLE || state_d == SLKD_IDLE) begin
            cnt_q <= ZERO_CNT;
        end else if (lp.ref_tick && cnt_q != FAIL_CNT) begin
            cnt_q <= cnt_q + CNT_W'(1); // Saturates at the fail count
        end
    end

    // Verdict only at the end of each comparison, not mid-window,
    // so a slow lag never flickers the flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            locked_q <= LOCK_RST_VAL;
        end else if (!lp.enable) begin
            locked_q <= 1'b1;
        end else if (state_q == SLKD_IDLE && both_now) begin
            locked_q <= 1'b1;
        end else if (lag_seen) begin
            locked_q <= (cnt_q < FAIL_CNT);
        end
    end

    assign lp.locked = locked_q;

endmodule : slkd_phase_win

// File: testbench/slkd_loop_model.sv
// Synthesizer loop model: reference and divider pulses with a set lag
module slkd_loop_model (
    // Control from the bench
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [7:0] lag_in,
    input  wire logic       lead_div_in,
    // Pulses towards the detector
    output logic            ref_out,
    output logic            div_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pulse_lead = 1'b0;
    logic pulse_lag  = 1'b0;
    // Which pin leads; only changed by the bench while both are idle
    assign ref_out = lead_div_in ? pulse_lag : pulse_lead;
    assign div_out = lead_div_in ? pulse_lead : pulse_lag;
    // Lead pulse, then the lagging one; pulses last 2 clocks to pass sync
    always begin
        @(posedge clk_in);
        while (!go_in) @(posedge clk_in);
        pulse_lead <= 1'b1;
        pulse_lag  <= (lag_in == 8'h00);
        repeat (2) @(posedge clk_in);
        pulse_lead <= 1'b0;
        pulse_lag  <= 1'b0;
        if (lag_in != 8'h00) begin
            repeat (lag_in) @(posedge clk_in);
            pulse_lag <= 1'b1;
            repeat (2) @(posedge clk_in);
            pulse_lag <= 1'b0;
        end
    end
endmodule : slkd_loop_model

// File: testbench/slkd_chk.sv
// Port assertions for the lock detector
module slkd_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic main_loop_enable_in,
    input wire logic aux_loop_enable_in,
    input wire logic offset_synth_enable_in,
    input wire logic offset_pd_lock_in,
    input wire logic main_ref_pulse_in,
    input wire logic main_div_pulse_in,
    input wire logic main_lock_out,
    input wire logic aux_lock_out,
    input wire logic lock_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] quiet_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Cycles without main pulses while enabled; saturates
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            quiet_q <= 4'h0;
        else if (main_ref_pulse_in || main_div_pulse_in ||
                 !main_loop_enable_in)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hF)
            quiet_q <= quiet_q + 4'h1;
    end
    property p_lock_and;
        lock_out |-> main_lock_out && aux_lock_out;
    endproperty
    a_lock_and: assert property (p_lock_and)
        else $error("combined lock high with a loop unlocked");
    property p_ofs_unlock;
        (offset_synth_enable_in && !offset_pd_lock_in) [*5] |-> !lock_out;
    endproperty
    a_ofs_unlock: assert property (p_ofs_unlock)
        else $error("combined lock high with offset loop unlocked");
    property p_standby;
        !offset_synth_enable_in [*2] ##0 (main_lock_out && aux_lock_out)
            |-> lock_out;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby offset loop not read as locked");
    property p_main_off;
        !main_loop_enable_in [*4] |-> main_lock_out;
    endproperty
    a_main_off: assert property (p_main_off)
        else $error("disabled main loop not locked");
    property p_aux_off;
        !aux_loop_enable_in [*4] |-> aux_lock_out;
    endproperty
    a_aux_off: assert property (p_aux_off)
        else $error("disabled aux loop not locked");
    // Verdicts only follow a comparison, so a quiet loop keeps its flag
    property p_quiet;
        quiet_q == 4'hF |-> $stable(main_lock_out);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("main lock changed without a comparison");
endmodule : slkd_chk
bind slkd_top slkd_chk u_chk (.clk_in, .rst_n_in, .main_loop_enable_in,
    .aux_loop_enable_in, .offset_synth_enable_in, .offset_pd_lock_in,
    .main_ref_pulse_in, .main_div_pulse_in, .main_lock_out, .aux_lock_out,
    .lock_out);

// File: testbench/slkd_top_tb.sv
// Self-checking bench for the lock detector
module slkd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, rst_n_in = 1'b0, go = 1'b0, ref_in = 1'b0;
    logic m_en = 1'b0, a_en = 1'b0, o_en = 1'b0, o_lock = 1'b0;
    logic lead_div = 1'b0;
    logic m_ref, m_div, a_ref, a_div, m_lk, a_lk, lk;
    logic [7:0] lag_m = 8'h00, lag_a = 8'h00;
    logic [2:0] ref_cnt = 3'h0;
    int n_mismatch = 0, cmp_count = 0;
    // Clock, and a reference input eight clocks per cycle
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        ref_cnt <= ref_cnt + 3'h1;
        ref_in <= ref_cnt[2];
    end
    slkd_top dut (.clk_in, .rst_n_in, .main_loop_enable_in(m_en),
        .aux_loop_enable_in(a_en), .offset_synth_enable_in(o_en),
        .reference_input_in(ref_in), .main_ref_pulse_in(m_ref),
        .main_div_pulse_in(m_div), .aux_ref_pulse_in(a_ref),
        .aux_div_pulse_in(a_div), .offset_pd_lock_in(o_lock),
        .main_lock_out(m_lk), .aux_lock_out(a_lk), .lock_out(lk));
    slkd_loop_model u_main (.clk_in, .go_in(go), .lag_in(lag_m),
        .lead_div_in(lead_div), .ref_out(m_ref), .div_out(m_div));
    slkd_loop_model u_aux (.clk_in, .go_in(go), .lag_in(lag_a),
        .lead_div_in(lead_div), .ref_out(a_ref), .div_out(a_div));
    task automatic check(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check
    // One comparison on both loops; 60 clocks covers lag, sync and verdict
    task automatic fire(input logic [7:0] lm, input logic [7:0] la);
        lag_m <= lm;
        lag_a <= la;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (60) @(posedge clk_in);
    endtask : fire
    task automatic s_unlock;
        m_en <= 1'b1;
        a_en <= 1'b1;
        fire(8'h1E, 8'h1E);
        check("main_lock", 1'b0, m_lk);
        check("aux_lock", 1'b0, a_lk);
        check("lock", 1'b0, lk);
    endtask : s_unlock
    task automatic s_locked;
        fire(8'h00, 8'h02);
        check("main_lock", 1'b1, m_lk);
        check("aux_lock", 1'b1, a_lk);
        check("lock", 1'b1, lk);
    endtask : s_locked
    task automatic s_offset;
        o_en <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("lock", 1'b0, lk);
        o_lock <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("lock", 1'b1, lk);
        o_lock <= 1'b0;
        o_en <= 1'b0;
        repeat (8) @(posedge clk_in);
        check("lock", 1'b1, lk);
    endtask : s_offset
    // Divider edge leading the reference edge, far and near
    task automatic s_div_lead;
        lead_div <= 1'b1;
        fire(8'h1E, 8'h02);
        check("main_lock", 1'b0, m_lk);
        check("aux_lock", 1'b1, a_lk);
        check("lock", 1'b0, lk);
        fire(8'h02, 8'h1E);
        check("main_lock", 1'b1, m_lk);
        check("aux_lock", 1'b0, a_lk);
        check("lock", 1'b0, lk);
        lead_div <= 1'b0;
    endtask : s_div_lead
    // Disabled loops ignore even badly lagging pulses
    task automatic s_disabled;
        fire(8'h1E, 8'h00);
        m_en <= 1'b0;
        a_en <= 1'b0;
        fire(8'h1E, 8'h1E);
        check("main_lock", 1'b1, m_lk);
        check("aux_lock", 1'b1, a_lk);
        check("lock", 1'b1, lk);
    endtask : s_disabled
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        s_unlock();
        s_locked();
        s_offset();
        s_div_lead();
        s_disabled();
        conclude();
    end
    // Watchdog well beyond the few hundred clocks the tests need
    initial begin
        repeat (3000) @(posedge clk_in);
        n_mismatch++;
        conclude();
    end
endmodule : slkd_top_tb
